// *** hdl/rtrc_top.sv ***
// Reference, temperature indicator and regulator mode control block
//
// Behaviour
// - Reference enable at bit 7, read-write, turns reference on or off, resets 0.
// - Read-only ready flag at bit 6, set only while reference output is usable.
// - Temperature sensor enable at bit 5, read-write, resets 0, off draws no current.
// - Range select at bit 4, resets 0; 1 high range, 0 low range.
// - Gain field: 11 four, 10 two, 01 one, 00 converter reference off; resets 00.
// - Bits 3 and 2 of reference control read zero and ignore writes.
// - Sleep mode select bit 1, resets 0; 1 power-save, 0 low-power in sleep.
// - Awake: high mode for external clock or fast oscillator, low for slow oscillator.
// - Sleep power-save forced low by brownout, fast peripheral clock, self-write or conversion.
// - Sensor output reaches one dedicated converter channel only.
// - After enable, ready stays low until reference circuits settle.
`timescale 1ns/1ps
`default_nettype none

`include "rtrc_cfg.svh"

module rtrc_top
(
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   // Register port
   input  wire rtrc_pkg::rtrc_addr_t  reg_addr,
   input  wire rtrc_pkg::rtrc_byte_t  reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output rtrc_pkg::rtrc_byte_t       reg_rdata,
   // Analog reference and sensor
   input  wire logic                  ref_settled,
   output logic                       reference_enable,
   output logic                       temp_sensor_enable,
   output logic                       temp_range_select,
   output logic [1:0]                 converter_ref_gain_select,
   output logic                       converter_ref_on,
   // Converter channel routing
   input  wire logic [2:0]            adc_channel_sel,
   output logic                       temp_channel_connect,
   // Regulator mode inputs
   input  wire logic                  sleep_active,
   input  wire logic                  external_clock_mode,
   input  wire logic                  internal_osc_slow,
   input  wire logic                  brownout_reset_enabled,
   input  wire logic                  fast_osc_peripheral,
   input  wire logic                  self_write_active,
   input  wire logic                  adc_converting,
   // Regulator mode output
   output rtrc_pkg::rtrc_mode_e       regulator_mode
);
   import rtrc_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed
   {
      logic       ref_en;
      logic       ready;
      logic       ts_en;
      logic       ts_rng;
      logic [1:0] gain;
      logic       slp_pm;
      logic       rsvd;
      logic       chan_conn;
      rtrc_byte_t rdata;
      rtrc_mode_e mode;
   } rtrc_state_s;

   rtrc_state_s state_q;
   rtrc_state_s state_d;
   logic        settled_sync;
   logic        wr_ref;
   logic        wr_reg;
   rtrc_byte_t  ref_view;
   rtrc_byte_t  reg_view;

   // ****************************************************************
   // Ready input crossing
   // ****************************************************************
   // Analog settle level is not clock-related, so it is synchronised
   rtrc_sync u_sync
   (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .async_in (ref_settled),
      .sync_out (settled_sync)
   );

   // ****************************************************************
   // Decode and read views
   // ****************************************************************
   // Write selects
   assign wr_ref = reg_wr && (reg_addr == `RTRC_OFF_REF_CTL);
   assign wr_reg = reg_wr && (reg_addr == `RTRC_OFF_REG_CTL);

   // Register images; unimplemented bits stay zero
   always_comb
   begin
      ref_view                   = 8'h00;
      ref_view[`RTRC_BIT_REF_EN] = state_q.ref_en;
      ref_view[`RTRC_BIT_REF_RDY] = state_q.ready;
      ref_view[`RTRC_BIT_TS_EN]  = state_q.ts_en;
      ref_view[`RTRC_BIT_TS_RNG] = state_q.ts_rng;
      ref_view[`RTRC_BIT_GAIN_HI:`RTRC_BIT_GAIN_LO] = state_q.gain;
      reg_view                   = 8'h00;
      reg_view[`RTRC_BIT_SLP_PM] = state_q.slp_pm;
      reg_view[`RTRC_BIT_RSVD]   = state_q.rsvd;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      state_d = state_q;
      // Control writes; bits 3:2 are never stored
      if (wr_ref)
      begin
         state_d.ref_en = reg_wdata[`RTRC_BIT_REF_EN];
         state_d.ts_en  = reg_wdata[`RTRC_BIT_TS_EN];
         state_d.ts_rng = reg_wdata[`RTRC_BIT_TS_RNG];
         state_d.gain   = reg_wdata[`RTRC_BIT_GAIN_HI:`RTRC_BIT_GAIN_LO];
      end
      if (wr_reg)
      begin
         state_d.slp_pm = reg_wdata[`RTRC_BIT_SLP_PM];
         state_d.rsvd   = reg_wdata[`RTRC_BIT_RSVD];
      end
      // Ready drops in the same edge that disable is written
      state_d.ready = state_d.ref_en && settled_sync;
      // Sensor routed only on its own channel and only when enabled
      state_d.chan_conn = state_q.ts_en && (adc_channel_sel == `RTRC_TEMP_CHAN);
      // Read data stand one cycle only
      if (reg_rd)
      begin
         case (reg_addr)
            `RTRC_OFF_REF_CTL: state_d.rdata = ref_view;
            `RTRC_OFF_REG_CTL: state_d.rdata = reg_view;
            default:           state_d.rdata = 8'h00;
         endcase
      end
      else
      begin
         state_d.rdata = 8'h00;
      end
      // Regulator mode selection
      if (!sleep_active)
      begin
         state_d.mode = (internal_osc_slow && !external_clock_mode) ? RTRC_MODE_LOW
                                                                      : RTRC_MODE_HIGH;
      end
      else if (state_q.slp_pm && !(brownout_reset_enabled || fast_osc_peripheral ||
                                    self_write_active || adc_converting))
      begin
         state_d.mode = RTRC_MODE_PSAVE;
      end
      else
      begin
         state_d.mode = RTRC_MODE_LOW;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q.ref_en    <= `RTRC_RST_REF_EN;
         state_q.ready     <= 1'b0;
         state_q.ts_en     <= `RTRC_RST_TS_EN;
         state_q.ts_rng    <= `RTRC_RST_TS_RNG;
         state_q.gain      <= `RTRC_RST_GAIN;
         state_q.slp_pm    <= `RTRC_RST_SLP_PM;
         state_q.rsvd      <= `RTRC_RST_RSVD;
         state_q.chan_conn <= 1'b0;
         state_q.rdata     <= 8'h00;
         state_q.mode      <= RTRC_MODE_HIGH;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // All data outputs but converter_ref_on come straight from the state register
   assign reg_rdata                 = state_q.rdata;
   assign reference_enable          = state_q.ref_en;
   assign temp_sensor_enable        = state_q.ts_en;
   assign temp_range_select         = state_q.ts_rng;
   assign converter_ref_gain_select = state_q.gain;
   // Buffer powered only for a nonzero gain code
   assign converter_ref_on          = (state_q.gain != `RTRC_GAIN_OFF);
   assign temp_channel_connect      = state_q.chan_conn;
   assign regulator_mode            = state_q.mode;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_ref_en_write: assert property (
      wr_ref |=> (reference_enable == $past(reg_wdata[`RTRC_BIT_REF_EN])))
      else $error("reference enable did not take written value");

   a_ready_needs_en: assert property (
      state_q.ready |-> (reference_enable && $past(settled_sync)))
      else $error("ready set without enable and settled reference");

   a_ready_clears: assert property (
      (wr_ref && !reg_wdata[`RTRC_BIT_REF_EN]) |=> !state_q.ready)
      else $error("ready not cleared on disable");

   a_ready_settles: assert property (
      (reference_enable && settled_sync && !wr_ref) |=> state_q.ready)
      else $error("ready not set after settling");

   a_ts_write: assert property (
      wr_ref |=> (temp_sensor_enable == $past(reg_wdata[`RTRC_BIT_TS_EN]))
                 && (temp_range_select == $past(reg_wdata[`RTRC_BIT_TS_RNG])))
      else $error("sensor controls did not take written value");

   a_gain_off: assert property (
      (wr_ref && reg_wdata[1:0] == `RTRC_GAIN_OFF) |=> !converter_ref_on)
      else $error("converter reference on with gain code off");

   a_unimpl_zero: assert property (
      (reg_rd && reg_addr == `RTRC_OFF_REF_CTL) |=> (reg_rdata[3:2] == 2'h0))
      else $error("unimplemented bits read nonzero");

   a_awake_mode: assert property (
      (!sleep_active && (external_clock_mode || !internal_osc_slow))
         |=> (regulator_mode == RTRC_MODE_HIGH))
      else $error("high mode not chosen while awake");

   a_sleep_forced: assert property (
      (sleep_active && (brownout_reset_enabled || adc_converting || self_write_active
                        || fast_osc_peripheral)) |=> (regulator_mode == RTRC_MODE_LOW))
      else $error("forcing condition did not select low mode");

   a_sleep_psave: assert property (
      (sleep_active && state_q.slp_pm && !brownout_reset_enabled && !adc_converting
       && !self_write_active && !fast_osc_peripheral) |=> (regulator_mode == RTRC_MODE_PSAVE))
      else $error("power-save not entered in sleep");

   a_temp_channel: assert property (
      temp_channel_connect |-> $past(temp_sensor_enable && adc_channel_sel == `RTRC_TEMP_CHAN))
      else $error("sensor routed to wrong channel");

   a_ready_off: assert property (
      !reference_enable |-> !state_q.ready)
      else $error("ready set while reference disabled");

   a_gain_write: assert property (
      wr_ref |=> (converter_ref_gain_select == $past(reg_wdata[`RTRC_BIT_GAIN_HI:`RTRC_BIT_GAIN_LO])))
      else $error("gain field did not take written value");

   a_reg_upper_zero: assert property (
      (reg_rd && reg_addr == `RTRC_OFF_REG_CTL) |=> (reg_rdata[7:2] == 6'h00))
      else $error("regulator control upper bits read nonzero");

   a_psave_in_sleep: assert property (
      (regulator_mode == RTRC_MODE_PSAVE) |-> $past(sleep_active && state_q.slp_pm))
      else $error("power-save chosen outside sleep");

   a_slow_osc_low: assert property (
      (!sleep_active && internal_osc_slow && !external_clock_mode) |=> (regulator_mode == RTRC_MODE_LOW))
      else $error("low mode not chosen for slow oscillator while awake");

   a_sensor_off: assert property (
      (wr_ref && !reg_wdata[`RTRC_BIT_TS_EN]) |=> !temp_sensor_enable)
      else $error("sensor still enabled after clear");

   // Main scenarios reached
   c_ready_rise: cover property (reference_enable ##1 state_q.ready);
   c_psave: cover property (regulator_mode == RTRC_MODE_PSAVE);
   c_read_ref: cover property (reg_rd && reg_addr == `RTRC_OFF_REF_CTL ##1 reg_rdata[7]);
   c_forced_low: cover property (sleep_active && adc_converting ##1 regulator_mode == RTRC_MODE_LOW);
   c_chan_conn: cover property (temp_channel_connect);

endmodule

`default_nettype wire

// *** include/rtrc_cfg.svh ***
// Offsets, field positions, reset values and codes of the reference/regulator control block
`ifndef RTRC_CFG_SVH
`define RTRC_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RTRC_OFF_REF_CTL    4'h0
`define RTRC_OFF_REG_CTL    4'h1

// ****************************************************************
// Field positions
// ****************************************************************
`define RTRC_BIT_REF_EN     7
`define RTRC_BIT_REF_RDY    6
`define RTRC_BIT_TS_EN      5
`define RTRC_BIT_TS_RNG     4
`define RTRC_BIT_GAIN_HI    1
`define RTRC_BIT_GAIN_LO    0
`define RTRC_BIT_SLP_PM     1
`define RTRC_BIT_RSVD       0

// ****************************************************************
// Reset values
// ****************************************************************
`define RTRC_RST_REF_EN     1'b0
`define RTRC_RST_TS_EN      1'b0
`define RTRC_RST_TS_RNG     1'b0
`define RTRC_RST_GAIN       2'h0
`define RTRC_RST_SLP_PM     1'b0
`define RTRC_RST_RSVD       1'b1

// ****************************************************************
// Codes
// ****************************************************************
`define RTRC_GAIN_OFF       2'h0
`define RTRC_GAIN_X1        2'h1
`define RTRC_GAIN_X2        2'h2
`define RTRC_GAIN_X4        2'h3
`define RTRC_TEMP_CHAN      3'h5

// ****************************************************************
// Timing counts
// ****************************************************************
// Sensor settle time before a conversion, 200 us at 25 ns per cycle
`define RTRC_TEMP_SETTLE_CYC 8000

`endif

// *** include/rtrc_pkg.sv ***
// Types shared by the reference/regulator control block
package rtrc_pkg;

   // ****************************************************************
   // Regulator power modes
   // ****************************************************************
   typedef enum logic [1:0]
   {
      RTRC_MODE_HIGH,
      RTRC_MODE_LOW,
      RTRC_MODE_PSAVE
   } rtrc_mode_e;

   typedef logic [7:0] rtrc_byte_t;
   typedef logic [3:0] rtrc_addr_t;

endpackage

// *** hdl/rtrc_sync.sv ***
// Two-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none

module rtrc_sync
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Level in and out
   input  wire logic async_in,
   output logic      sync_out
);

   typedef struct packed
   {
      logic meta;
      logic stable;
   } rtrc_sync_s;

   rtrc_sync_s state_q;
   rtrc_sync_s state_d;

   // Second stage reads only the first
   always_comb
   begin
      state_d.meta   = async_in;
      state_d.stable = state_q.meta;
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign sync_out = state_q.stable;

endmodule

`default_nettype wire

// *** bench/rtrc_top_tb_top.sv ***
// Self-checking testbench for the reference/regulator control block
`timescale 1ns/1ps
`default_nettype none

`include "rtrc_cfg.svh"

module rtrc_top_tb_top;
   import rtrc_pkg::*;

   // ****************************************************************
   // Signals and model state
   // ****************************************************************
   logic       ref_clk     = 1'b0;
   logic       rst_n       = 1'b0;
   rtrc_addr_t reg_addr    = 4'h0;
   rtrc_byte_t reg_wdata   = 8'h00;
   logic       reg_wr      = 1'b0;
   logic       reg_rd      = 1'b0;
   logic       ref_settled = 1'b0;
   logic [2:0] adc_ch      = 3'h0;
   logic [6:0] mode_in     = 7'h00;  // Sleep, ext, slow, brownout, fast osc, self-write, conversion
   rtrc_byte_t reg_rdata;
   logic       ref_en, ts_en, ts_rng, ref_on, ch_conn;
   logic [1:0] gain;
   rtrc_mode_e reg_mode;
   rtrc_byte_t ref_img, reg_img, d;
   logic [31:0] r;
   int         errors  = 0;
   int         n_tests = 0;
   int         exp_mode;

   // Free-running 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   rtrc_top i_rtrc_top
   (
      .ref_clk                   (ref_clk),
      .rst_n                     (rst_n),
      .reg_addr                  (reg_addr),
      .reg_wdata                 (reg_wdata),
      .reg_wr                    (reg_wr),
      .reg_rd                    (reg_rd),
      .reg_rdata                 (reg_rdata),
      .ref_settled               (ref_settled),
      .reference_enable          (ref_en),
      .temp_sensor_enable        (ts_en),
      .temp_range_select         (ts_rng),
      .converter_ref_gain_select (gain),
      .converter_ref_on          (ref_on),
      .adc_channel_sel           (adc_ch),
      .temp_channel_connect      (ch_conn),
      .sleep_active              (mode_in[6]),
      .external_clock_mode       (mode_in[5]),
      .internal_osc_slow         (mode_in[4]),
      .brownout_reset_enabled    (mode_in[3]),
      .fast_osc_peripheral       (mode_in[2]),
      .self_write_active         (mode_in[1]),
      .adc_converting            (mode_in[0]),
      .regulator_mode            (reg_mode)
   );

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] want);
      n_tests++;
      if (seen !== want)
      begin
         errors++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask

   // One-cycle write; outputs land at the strobe's sampling edge
   task automatic wr(input rtrc_addr_t a, input rtrc_byte_t v);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Read data only stands in the cycle after the strobe, so sample there
   task automatic rchk(input rtrc_addr_t a, input rtrc_byte_t want);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, want);
   endtask

   task automatic close_out;
      $display("Counts: %0d compared, %0d mismatched", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Watchdog, far beyond the roughly 8350 cycles the tests need
   initial
   begin
      #500000;
      errors++;
      close_out();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      void'($urandom(32'h1f1c));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(`RTRC_OFF_REF_CTL, 8'h00);
      rchk(`RTRC_OFF_REG_CTL, 8'h01);
      chk({6'h00, reg_mode}, 8'(RTRC_MODE_HIGH));
      $display("test reset_values done");

      // Fields of reference control, every gain code twice, ready held off
      for (int i = 0; i < 8; i++)
      begin
         r = $urandom;
         d = {r[7:2], 2'(i)};
         ref_img = d & 8'hB3;
         wr(`RTRC_OFF_REF_CTL, d);
         chk({ref_en, 1'b0, ts_en, ts_rng, 2'b00, gain}, ref_img);
         chk({7'h00, ref_on}, {7'h00, gain != 2'b00});
         rchk(`RTRC_OFF_REF_CTL, ref_img);
      end
      $display("test reference_fields done");

      // Ready follows the settled input only while enabled
      wr(`RTRC_OFF_REF_CTL, 8'h80);
      rchk(`RTRC_OFF_REF_CTL, 8'h80);
      @(posedge ref_clk);
      ref_settled <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rchk(`RTRC_OFF_REF_CTL, 8'hC0);
      @(posedge ref_clk);
      ref_settled <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rchk(`RTRC_OFF_REF_CTL, 8'h80);
      @(posedge ref_clk);
      ref_settled <= 1'b1;
      repeat (4) @(posedge ref_clk);
      wr(`RTRC_OFF_REF_CTL, 8'h00);
      rchk(`RTRC_OFF_REF_CTL, 8'h00);
      $display("test ready_flag done");

      // Regulator control: upper bits read zero, reserved bit stored
      for (int i = 0; i < 6; i++)
      begin
         r = $urandom;
         // Software keeps the reserved bit set
         reg_img = (r[7:0] & 8'h03) | 8'h01;
         wr(`RTRC_OFF_REG_CTL, r[7:0] | 8'h01);
         rchk(`RTRC_OFF_REG_CTL, reg_img);
      end
      wr(4'h7, 8'hFF);
      rchk(4'h7, 8'h00);
      rchk(`RTRC_OFF_REF_CTL, 8'h00);
      rchk(`RTRC_OFF_REG_CTL, reg_img);
      $display("test regulator_register done");

      // Regulator mode; forcing inputs kept sparse so power-save shows up
      for (int i = 0; i < 96; i++)
      begin
         if (i % 24 == 0)
         begin
            reg_img = ((i / 24) % 2 == 1) ? 8'h01 : 8'h03;
            wr(`RTRC_OFF_REG_CTL, reg_img);
         end
         r = $urandom;
         @(posedge ref_clk);
         mode_in <= {r[2:0], (r[5] ? 4'(1 << r[4:3]) : 4'h0)};
         @(posedge ref_clk);
         #1;
         if (!mode_in[6])
            exp_mode = (mode_in[4] && !mode_in[5]) ? RTRC_MODE_LOW : RTRC_MODE_HIGH;
         else
            exp_mode = (reg_img[1] && mode_in[3:0] == 4'h0) ? RTRC_MODE_PSAVE : RTRC_MODE_LOW;
         chk({6'h00, reg_mode}, 8'(exp_mode));
      end
      $display("test regulator_mode done");

      // Sensor channel routing, with sensor off then on
      for (int i = 0; i < 16; i++)
      begin
         if (i % 8 == 0)
            wr(`RTRC_OFF_REF_CTL, (i == 8) ? 8'h20 : 8'h00);
         @(posedge ref_clk);
         adc_ch <= 3'(i);
         @(posedge ref_clk);
         #1;
         chk({7'h00, ch_conn}, {7'h00, (i >= 8) && (3'(i) == `RTRC_TEMP_CHAN)});
      end
      $display("test sensor_channel done");

      // Asleep with sensor routed: power-save until a conversion forces low mode
      wr(`RTRC_OFF_REG_CTL, 8'h03);
      @(posedge ref_clk);
      adc_ch  <= `RTRC_TEMP_CHAN;
      mode_in <= 7'h40;
      // No conversion before the sensor has settled
      repeat (`RTRC_TEMP_SETTLE_CYC) @(posedge ref_clk);
      #1;
      chk({7'h00, ch_conn}, 8'h01);
      chk({6'h00, reg_mode}, 8'(RTRC_MODE_PSAVE));
      @(posedge ref_clk);
      mode_in <= 7'h41;
      @(posedge ref_clk);
      #1;
      chk({6'h00, reg_mode}, 8'(RTRC_MODE_LOW));
      $display("test sensor_settle done");

      // Reset in mid-run restores register defaults
      @(posedge ref_clk);
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(`RTRC_OFF_REG_CTL, 8'h01);
      rchk(`RTRC_OFF_REF_CTL, 8'h00);
      $display("test mid_reset done");
      close_out();
   end

endmodule

`default_nettype wire
